// file: verilog/scrc_regs.vh
`ifndef SCRC_REGS_VH
`define SCRC_REGS_VH

// Clock control states
`define SCRC_ST_RUN      2'h0
`define SCRC_ST_ANNOUNCE 2'h1
`define SCRC_ST_SLOW     2'h2
`define SCRC_ST_STOP     2'h3

// Socket clock edges the clock-run line stays released before a slow or stop
`define SCRC_ANNOUNCE_CLKS 8'h04
// Host clock rising edges per half period of the slowed socket clock
`define SCRC_SLOW_DIV      8'h08
// Block clock edges the released clock-run line needs before its synchronised level is trusted
`define SCRC_RUN_SETTLE    3'h5
// Width of the shared address/data lines, bit 31 most significant
`define SCRC_AD_WIDTH      32
// Reset values
`define SCRC_RST_SOCKET_RESET_N 1'b0
`define SCRC_RST_CLOCK          1'b0
`define SCRC_RST_COUNT          8'h00

`endif

// file: verilog/scrc_sync3.v
`timescale 1ns/1ps
module scrc_sync3 #(
   parameter W = 1
) (
   input  wire         core_clk,
   input  wire         reset,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] meta_r;
   reg [W-1:0] st2_r;
   reg [W-1:0] st3_r;
   integer i;

   // Three stages; a bit changes only once stages two and three agree
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         meta_r   <= {W{1'b0}};
         st2_r    <= {W{1'b0}};
         st3_r    <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_r <= async_in;
         st2_r  <= meta_r;
         st3_r  <= st2_r;
         for (i = 0; i < W; i = i + 1) begin
            if (st2_r[i] == st3_r[i]) begin
               sync_out[i] <= st3_r[i];
            end
         end
      end
   end
endmodule

// file: verilog/scrc_ctrl.v
// Operation
// R1: Socket signals sample on socket clock rise, except reset, run, status, detect, sense lines.
// R2: Socket clock runs at the host bus clock frequency in normal operation.
// R3: Controller may slow or stop the socket clock; a stopped clock sits low.
// R4: Card asks for a faster clock by pulling the clock-run line.
// R5: Controller releases clock-run line to announce a coming clock decrease.
// R6: Card resets its own registers and sequencers while socket reset is asserted.
// R7: During socket reset the card floats; controller drives the lines to valid levels.
// R8: Socket reset asserts at any time but releases only with a socket clock rise.
// R9: Shared lines carry 32-bit address then data, bit 31 most significant.
// R10: Slow or stop only after announcing, and only with no card speed-up pending.
`timescale 1ns/1ps
`include "scrc_regs.vh"
module scrc_ctrl #(
   parameter       AD_W          = `SCRC_AD_WIDTH,
   parameter [7:0] ANNOUNCE_CLKS = `SCRC_ANNOUNCE_CLKS,
   parameter [7:0] SLOW_DIV      = `SCRC_SLOW_DIV
) (
   input  wire            core_clk,
   input  wire            reset,
   input  wire            host_bus_clock,
   input  wire            power_slow_req,
   input  wire            power_stop_req,
   input  wire            socket_reset_req,
   input  wire [AD_W-1:0] ad_drive_data,
   input  wire            ad_drive_en,
   input  wire [AD_W-1:0] shared_address_data_lines_in,
   input  wire            clock_run_line_in,
   output reg             socket_clock,
   output reg             socket_reset_n,
   output reg             clock_run_line_out,
   output reg             clock_run_line_oe_n,
   output reg  [AD_W-1:0] shared_address_data_lines_out,
   output reg             shared_address_data_lines_oe_n,
   output reg  [AD_W-1:0] ad_sampled,
   output reg             ad_sampled_valid,
   output reg  [1:0]      clock_mode,
   output reg             card_speedup_pending
);
   wire [1:0] sync_w;
   wire       host_clk_s;
   wire       run_line_s;
   reg        host_prev_r;
   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg  [7:0] cnt_r;
   reg  [7:0] cnt_nxt;
   reg        clk_nxt;
   reg        run_drive_nxt;
   reg        pend_nxt;
   wire       host_rise;
   wire       sock_rise;
   wire       clk_low_ok;
   wire       card_asks;
   reg  [2:0] settle_r;

   // Rising edge of a level given its previous value
   function edge_up;
      input prev;
      input cur;
      begin
         edge_up = cur & ~prev;
      end
   endfunction

   // Host bus clock and clock-run line are both asynchronous pins
   scrc_sync3 #(
      .W (2)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in ({clock_run_line_in, host_bus_clock}),
      .sync_out (sync_w)
   );
   assign host_clk_s = sync_w[0];
   assign run_line_s = sync_w[1];

   assign host_rise  = edge_up(host_prev_r, host_clk_s);
   assign sock_rise  = edge_up(socket_clock, clk_nxt);
   // Slow and stop are entered and left only with both clocks low, so no runt pulse appears
   assign clk_low_ok = ~socket_clock & ~host_clk_s;
   // Card pulls the released line low to ask for full speed
   // Only once the synchroniser has caught up with the release, so our own old drive is not a request
   assign card_asks  = clock_run_line_oe_n & (settle_r == `SCRC_RUN_SETTLE) & ~run_line_s; // R4

   // Counts block cycles since the clock-run line was released
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         settle_r <= 3'h0;
      end else if (!clock_run_line_oe_n) begin
         settle_r <= 3'h0;
      end else if (settle_r != `SCRC_RUN_SETTLE) begin
         settle_r <= settle_r + 3'h1;
      end
   end

   // Clock state machine
   always @* begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      clk_nxt       = socket_clock;
      run_drive_nxt = 1'b1;
      pend_nxt      = card_speedup_pending;
      case (state_r)
         `SCRC_ST_RUN: begin
            clk_nxt = host_clk_s; // R2
            // Socket clock rise, taken from the pin it follows to keep this process loop free
            if (host_clk_s && !socket_clock && cnt_r != ANNOUNCE_CLKS) begin
               cnt_nxt = cnt_r + 8'h01;
            end
            if (cnt_r == ANNOUNCE_CLKS) begin
               pend_nxt = 1'b0;
            end
            if ((power_slow_req | power_stop_req) && !card_speedup_pending && socket_reset_n &&
                cnt_r == ANNOUNCE_CLKS) begin
               state_nxt = `SCRC_ST_ANNOUNCE; // R10
               cnt_nxt   = `SCRC_RST_COUNT;
               run_drive_nxt = 1'b0; // R5
            end
         end
         `SCRC_ST_ANNOUNCE: begin
            clk_nxt       = host_clk_s;
            run_drive_nxt = 1'b0; // R5
            if (host_clk_s && !socket_clock && cnt_r != ANNOUNCE_CLKS) begin
               cnt_nxt = cnt_r + 8'h01;
            end
            if (card_asks || !(power_slow_req | power_stop_req)) begin
               pend_nxt      = card_asks;
               state_nxt     = `SCRC_ST_RUN;
               cnt_nxt       = `SCRC_RST_COUNT;
               run_drive_nxt = 1'b1;
            end else if (cnt_r == ANNOUNCE_CLKS && clk_low_ok) begin
               state_nxt = power_stop_req ? `SCRC_ST_STOP : `SCRC_ST_SLOW; // R10
               cnt_nxt   = `SCRC_RST_COUNT;
               clk_nxt   = 1'b0;
            end
         end
         `SCRC_ST_SLOW: begin
            run_drive_nxt = 1'b0;
            if (host_rise) begin
               if (cnt_r == SLOW_DIV - 8'h01) begin
                  cnt_nxt = `SCRC_RST_COUNT;
                  clk_nxt = ~socket_clock; // R3
               end else begin
                  cnt_nxt = cnt_r + 8'h01;
               end
            end
            if (card_asks) begin
               pend_nxt = 1'b1;
            end
            if ((card_asks || card_speedup_pending || !power_slow_req || power_stop_req) && clk_low_ok) begin
               state_nxt     = `SCRC_ST_RUN;
               cnt_nxt       = `SCRC_RST_COUNT;
               clk_nxt       = 1'b0;
               run_drive_nxt = 1'b1;
            end
         end
         `SCRC_ST_STOP: begin
            clk_nxt       = 1'b0; // R3
            run_drive_nxt = 1'b0;
            if (card_asks) begin
               pend_nxt = 1'b1;
            end
            if ((card_asks || card_speedup_pending || !power_stop_req) && !host_clk_s) begin
               state_nxt     = `SCRC_ST_RUN;
               cnt_nxt       = `SCRC_RST_COUNT;
               run_drive_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = `SCRC_ST_RUN;
            cnt_nxt   = `SCRC_RST_COUNT;
            clk_nxt   = 1'b0;
         end
      endcase
   end

   // Clock, clock-run drive and mode registers
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         host_prev_r          <= 1'b0;
         state_r              <= `SCRC_ST_RUN;
         cnt_r                <= `SCRC_RST_COUNT;
         socket_clock         <= `SCRC_RST_CLOCK;
         clock_run_line_out   <= 1'b0;
         clock_run_line_oe_n  <= 1'b0;
         clock_mode           <= `SCRC_ST_RUN;
         card_speedup_pending <= 1'b0;
      end else begin
         host_prev_r          <= host_clk_s;
         state_r              <= state_nxt;
         cnt_r                <= cnt_nxt;
         socket_clock         <= clk_nxt;
         clock_run_line_out   <= 1'b0;
         clock_run_line_oe_n  <= ~run_drive_nxt; // R5
         clock_mode           <= state_nxt;
         card_speedup_pending <= pend_nxt; // R10
      end
   end

   // Socket reset: asserts at once, releases on the edge the socket clock rises
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         socket_reset_n <= `SCRC_RST_SOCKET_RESET_N; // R8
      end else if (socket_reset_req) begin
         socket_reset_n <= 1'b0; // R8
      end else if (!socket_reset_n && sock_rise) begin
         socket_reset_n <= 1'b1; // R8
      end
   end

   // Shared lines: driven to zero while the card is held in reset
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shared_address_data_lines_out  <= {AD_W{1'b0}};
         shared_address_data_lines_oe_n <= 1'b0;
      end else if (socket_reset_req || !socket_reset_n) begin
         shared_address_data_lines_out  <= {AD_W{1'b0}}; // R7
         shared_address_data_lines_oe_n <= 1'b0; // R7
      end else begin
         shared_address_data_lines_out  <= ad_drive_data; // R9
         shared_address_data_lines_oe_n <= ~ad_drive_en;
      end
   end

   // Capture the shared lines at each socket clock rise, bit 31 on top
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ad_sampled       <= {AD_W{1'b0}};
         ad_sampled_valid <= 1'b0;
      end else begin
         ad_sampled_valid <= sock_rise & socket_reset_n; // R1
         if (sock_rise) begin
            ad_sampled <= shared_address_data_lines_in; // R1 R9
         end
      end
   end
endmodule

// file: test/scrc_chk.sv
`timescale 1ns/1ps
module scrc_chk #(
   parameter AD_W = 32
) (
   input wire            core_clk,
   input wire            reset,
   input wire            socket_reset_req,
   input wire            socket_clock,
   input wire            socket_reset_n,
   input wire            clock_run_line_oe_n,
   input wire [AD_W-1:0] shared_address_data_lines_out,
   input wire            shared_address_data_lines_oe_n,
   input wire            ad_sampled_valid,
   input wire [1:0]      clock_mode,
   input wire            card_speedup_pending
);
   // One domain; reset disables every check
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // A decrease is entered only straight from the announce step
   sequence s_enter_low; $rose(clock_mode[1]); endsequence
   sequence s_from_announce; $past(clock_mode) == 2'h1; endsequence
   property p_announce; s_enter_low |-> s_from_announce; endproperty
   a_announce: assert property (p_announce) else $error("decrease not announced");
   property p_release; clock_mode != 2'h0 |-> clock_run_line_oe_n; endproperty
   a_release: assert property (p_release) else $error("run line held low");
   property p_stop_low; clock_mode == 2'h3 |-> !socket_clock; endproperty
   a_stop_low: assert property (p_stop_low) else $error("stopped clock high");
   property p_rst_take; socket_reset_req |=> !socket_reset_n; endproperty
   a_rst_take: assert property (p_rst_take) else $error("socket reset late");
   property p_rel_sync; $rose(socket_reset_n) |-> $rose(socket_clock); endproperty
   a_rel_sync: assert property (p_rel_sync) else $error("reset release off clock");
   property p_rst_lines; !socket_reset_n |-> !shared_address_data_lines_oe_n && shared_address_data_lines_out == '0;
   endproperty
   a_rst_lines: assert property (p_rst_lines) else $error("lines not driven in reset");
   property p_sample; ad_sampled_valid |-> $rose(socket_clock); endproperty
   a_sample: assert property (p_sample) else $error("sample off rising edge");
   property p_no_pend; clock_mode == 2'h1 && $past(clock_mode) == 2'h0 |-> !$past(card_speedup_pending)
      && $past(socket_reset_n); endproperty
   a_no_pend: assert property (p_no_pend) else $error("announce with card request");
endmodule
bind scrc_ctrl scrc_chk #(.AD_W(AD_W)) u_chk (.core_clk, .reset, .socket_reset_req, .socket_clock, .socket_reset_n,
   .clock_run_line_oe_n, .shared_address_data_lines_out, .shared_address_data_lines_oe_n, .ad_sampled_valid,
   .clock_mode, .card_speedup_pending);

// file: test/scrc_card.sv
`timescale 1ns/1ps
module scrc_card (
   input  wire        socket_clock,
   input  wire        socket_reset_n,
   input  wire        pull_req,
   output reg  [31:0] word_r,
   output reg         drive_r,
   output wire        run_pull
);
   // Pulls clock-run low on command to ask for speed
   assign run_pull = pull_req;
   // Floats in reset; a new word on each fall, settled for the next rise
   always @(negedge socket_clock or negedge socket_reset_n) begin
      if (!socket_reset_n) begin
         drive_r <= 1'h0;
         word_r  <= 32'h8000_0000;
      end else begin
         drive_r <= 1'h1;
         word_r  <= {word_r[30:0], ~word_r[31]};
      end
   end
endmodule

// file: test/socket_clock_reset_control_bench.sv
`timescale 1ns/1ps
module socket_clock_reset_control_bench;
   reg         core_clk = 1'h0, reset = 1'h1, host_bus_clock = 1'h0, pull_req = 1'h0, ad_drive_en = 1'h0;
   reg         power_slow_req = 1'h0, power_stop_req = 1'h0, socket_reset_req = 1'h0;
   reg  [31:0] ad_drive_data = 32'h0;
   reg         prev_clk = 1'h0;
   wire [31:0] shared_address_data_lines_in, shared_address_data_lines_out, ad_sampled, word_r;
   wire [1:0]  clock_mode;
   wire        socket_clock, socket_reset_n, clock_run_line_out, clock_run_line_oe_n, clock_run_line_in, run_pull;
   wire        shared_address_data_lines_oe_n, ad_sampled_valid, card_speedup_pending, drive_r;
   integer     errors = 0, checks_done = 0, cyc = 0, c, i;
   // Block clock, and host clock at an unrelated phase
   always #50 core_clk = ~core_clk;
   initial #137 forever #400 host_bus_clock = ~host_bus_clock;
   // Pull-up on clock-run; undriven shared lines show a changing pattern
   assign clock_run_line_in = !((!clock_run_line_oe_n && !clock_run_line_out) || run_pull);
   assign shared_address_data_lines_in = !shared_address_data_lines_oe_n ? shared_address_data_lines_out
                                       : drive_r ? word_r : ~cyc;
   scrc_ctrl u_scrc_ctrl (.core_clk, .reset, .host_bus_clock, .power_slow_req, .power_stop_req, .socket_reset_req,
      .ad_drive_data, .ad_drive_en, .shared_address_data_lines_in, .clock_run_line_in, .socket_clock,
      .socket_reset_n, .clock_run_line_out, .clock_run_line_oe_n, .shared_address_data_lines_out,
      .shared_address_data_lines_oe_n, .ad_sampled, .ad_sampled_valid, .clock_mode, .card_speedup_pending);
   scrc_card u_scrc_card (.socket_clock, .socket_reset_n, .pull_req, .word_r, .drive_r, .run_pull);
   task chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task till_mode(input logic [1:0] m, input integer n);
      for (i = 0; i < n && clock_mode !== m; i++) @(negedge core_clk);
   endtask
   // Counts socket clock rises over n block cycles into c
   task rises(input integer n);
      c = 0;
      prev_clk = socket_clock;
      for (i = 0; i < n; i++) begin
         @(negedge core_clk);
         if (socket_clock && !prev_clk) c++;
         prev_clk = socket_clock;
      end
   endtask
   task t_run;
      rises(20);
      rises(128);
      chk("run rises", c >= 15 && c <= 17, 1);
      chk("socket_reset_n", socket_reset_n, 1);
      $display("run done");
   endtask
   task t_sample;
      for (i = 0; i < 40 && ad_sampled_valid !== 1'h1; i++) @(negedge core_clk);
      chk("valid", ad_sampled_valid, 1);
      chk("ad_sampled", ad_sampled, word_r);
      $display("sample done");
   endtask
   task t_reset;
      @(posedge core_clk);
      ad_drive_en <= 1'h1;
      ad_drive_data <= 32'hA5C3_0F96;
      socket_reset_req <= 1'h1;
      repeat (3) @(negedge core_clk);
      chk("socket_reset_n", socket_reset_n, 0);
      chk("ad oe_n", shared_address_data_lines_oe_n, 0);
      chk("ad out", shared_address_data_lines_out, 0);
      @(posedge core_clk) socket_reset_req <= 1'h0;
      for (i = 0; i < 40 && socket_reset_n !== 1'h1; i++) @(negedge core_clk);
      chk("clock at release", socket_clock, 1);
      @(negedge core_clk);
      chk("ad out", shared_address_data_lines_out, 32'hA5C3_0F96);
      @(posedge core_clk) ad_drive_en <= 1'h0;
      $display("reset done");
   endtask
   task t_stop;
      @(posedge core_clk) power_stop_req <= 1'h1;
      till_mode(2'h3, 300);
      chk("mode", clock_mode, 2'h3);
      chk("run oe_n", clock_run_line_oe_n, 1);
      chk("run out", clock_run_line_out, 0);
      rises(60);
      chk("stop rises", c, 0);
      chk("clock low", socket_clock, 0);
      @(posedge core_clk) power_stop_req <= 1'h0;
      till_mode(2'h0, 60);
      chk("run oe_n", clock_run_line_oe_n, 0);
      $display("stop done");
   endtask
   task t_slow;
      @(posedge core_clk) power_slow_req <= 1'h1;
      till_mode(2'h2, 300);
      chk("mode", clock_mode, 2'h2);
      rises(640);
      chk("slow rises", c >= 4 && c <= 6, 1);
      @(posedge core_clk) pull_req <= 1'h1;
      till_mode(2'h0, 300);
      chk("mode", clock_mode, 2'h0);
      chk("pending", card_speedup_pending, 1);
      @(posedge core_clk);
      pull_req <= 1'h0;
      power_slow_req <= 1'h0;
      $display("slow done");
   endtask
   // Reset for ten cycles, then each scenario in turn
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'h0;
      t_run;
      t_sample;
      t_reset;
      t_stop;
      t_slow;
      wrap_up;
   end
   // Cuts a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors = errors + 1;
         wrap_up;
      end
   end
endmodule
